// *** inc/pwc_pkg.sv ***
package pwc_pkg;

  // Register addresses as seen on the plain register port.
  localparam logic [7:0] PWC_ADDR_ENC_WY_UX   = 8'h15;
  localparam logic [7:0] PWC_ADDR_ENC_VN      = 8'h16;
  localparam logic [7:0] PWC_ADDR_POLARITY    = 8'h17;
  localparam logic [7:0] PWC_ADDR_PERIOD      = 8'h18;
  localparam logic [7:0] PWC_ADDR_DEAD_TIME   = 8'h19;
  localparam logic [7:0] PWC_ADDR_CHOP        = 8'h1A;
  localparam logic [7:0] PWC_ADDR_MOTOR       = 8'h1B;
  localparam logic [7:0] PWC_ADDR_EXT_ANGLE   = 8'h1C;
  localparam logic [7:0] PWC_ADDR_FA_DIR      = 8'h1F;
  localparam logic [7:0] PWC_ADDR_FA_ACCEL    = 8'h20;
  localparam logic [7:0] PWC_ADDR_FA_TARGET   = 8'h21;
  localparam logic [7:0] PWC_ADDR_FA_VEL_ACT  = 8'h22;
  localparam logic [7:0] PWC_ADDR_FA_PHI      = 8'h23;
  localparam logic [7:0] PWC_ADDR_VEL_LIMIT   = 8'h60;

  // Field positions.
  localparam int PWC_POL_LOW_BIT    = 0;
  localparam int PWC_POL_HIGH_BIT   = 1;
  localparam int PWC_SV_EN_BIT      = 8;
  localparam int PWC_FA_DIR_BIT     = 12;
  localparam int PWC_MOTOR_TYPE_LSB = 16;

  // Reset values.
  localparam logic [1:0]  PWC_RST_POLARITY  = 2'h3;
  localparam logic [11:0] PWC_RST_PERIOD    = 12'hF9F;
  localparam logic [7:0]  PWC_RST_DEAD_TIME = 8'h14;
  localparam logic [7:0]  PWC_RST_CHOP      = 8'h00;
  localparam logic [15:0] PWC_RST_POLE_PAIRS = 16'h0001;
  localparam logic [7:0]  PWC_RST_MOTOR_TYPE = 8'h00;
  localparam logic [31:0] PWC_RST_VEL_LIMIT  = 32'h7FFFFFFF;

  // Timing: dead time unit and the core clock rate.
  localparam int PWC_CLK_PERIOD_NS = 10;
  localparam int PWC_DEAD_UNIT_NS  = 10;
  localparam int PWC_DEAD_UNIT_CYC = (PWC_DEAD_UNIT_NS + PWC_CLK_PERIOD_NS - 1) / PWC_CLK_PERIOD_NS;

  // Chopper modes.
  typedef enum logic [7:0] {
    PWC_CHOP_FREE0   = 8'h00,
    PWC_CHOP_LOW_ON  = 8'h01,
    PWC_CHOP_HIGH_ON = 8'h02,
    PWC_CHOP_FREE3   = 8'h03,
    PWC_CHOP_FREE4   = 8'h04,
    PWC_CHOP_LOW_PWM = 8'h05,
    PWC_CHOP_HI_PWM  = 8'h06,
    PWC_CHOP_CENTER  = 8'h07
  } pwc_chop_t;

  // Motor topologies.
  localparam logic [7:0] PWC_MOTOR_NONE    = 8'h00;
  localparam logic [7:0] PWC_MOTOR_DC      = 8'h01;
  localparam logic [7:0] PWC_MOTOR_STEPPER = 8'h02;
  localparam logic [7:0] PWC_MOTOR_BLDC    = 8'h03;

endpackage

// *** design/pwc_core.sv ***
module pwc_core
  import pwc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic [11:0] duty_u,
  input  wire logic [11:0] duty_v,
  input  wire logic [11:0] duty_w,
  input  wire logic [15:0] encoder_sense_first,
  input  wire logic [15:0] encoder_sense_second,
  input  wire logic [15:0] encoder_sense_third,
  input  wire logic [15:0] mech_angle,
  output logic      [15:0] elec_angle,
  output logic      [15:0] ext_elec_angle,
  output logic      [15:0] free_angle,
  output logic             sv_active,
  output logic             period_start,
  output logic      [2:0]  gate_high,
  output logic      [2:0]  gate_low
);

  ////////////////////////////////////////////////////////////////////////////
  // Software visible registers.
  logic [1:0]  gate_polarity_bits_q;
  logic [11:0] period_count_field_q;
  logic [7:0]  low_side_dead_time_q;
  logic [7:0]  high_side_dead_time_q;
  logic [7:0]  chopper_mode_field_q;
  logic        space_vector_enable_q;
  logic [15:0] pole_pairs_q;
  logic [7:0]  motor_type_q;
  logic [15:0] ext_angle_q;
  logic        fa_dir_q;
  logic [31:0] fa_accel_q;
  logic [31:0] fa_target_q;
  logic [31:0] velocity_loop_limit_q;

  // Settings in force for the current period.
  logic [11:0] act_period_q;
  logic [7:0]  act_dead_low_q;
  logic [7:0]  act_dead_high_q;
  logic [7:0]  act_chop_q;

  // Period counter and free angle generator state.
  logic [11:0] cnt_q;
  logic [31:0] fa_vel_q;
  logic [31:0] fa_acc_q;
  logic [15:0] elec_angle_d;

  // Returns true when a write strobe targets the given address.
  function automatic logic wr_hit(input logic [7:0] a);
    return reg_wr && (reg_addr == a);
  endfunction

  // Register writes; each field keeps its documented position.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gate_polarity_bits_q  <= PWC_RST_POLARITY;
      period_count_field_q  <= PWC_RST_PERIOD;
      low_side_dead_time_q  <= PWC_RST_DEAD_TIME;
      high_side_dead_time_q <= PWC_RST_DEAD_TIME;
      chopper_mode_field_q  <= PWC_RST_CHOP;
      space_vector_enable_q <= 1'b0;
      pole_pairs_q          <= PWC_RST_POLE_PAIRS;
      motor_type_q          <= PWC_RST_MOTOR_TYPE;
      ext_angle_q           <= 16'h0000;
      fa_dir_q              <= 1'b0;
      fa_accel_q            <= 32'h00000000;
      fa_target_q           <= 32'h00000000;
      velocity_loop_limit_q <= PWC_RST_VEL_LIMIT;
    end else begin
      if (wr_hit(PWC_ADDR_POLARITY)) begin
        gate_polarity_bits_q <= reg_wdata[PWC_POL_HIGH_BIT:PWC_POL_LOW_BIT];
      end
      if (wr_hit(PWC_ADDR_PERIOD)) begin
        period_count_field_q <= reg_wdata[11:0];
      end
      if (wr_hit(PWC_ADDR_DEAD_TIME)) begin
        low_side_dead_time_q  <= reg_wdata[7:0];
        high_side_dead_time_q <= reg_wdata[15:8];
      end
      if (wr_hit(PWC_ADDR_CHOP)) begin
        chopper_mode_field_q  <= reg_wdata[7:0];
        space_vector_enable_q <= reg_wdata[PWC_SV_EN_BIT];
      end
      if (wr_hit(PWC_ADDR_MOTOR)) begin
        pole_pairs_q <= reg_wdata[15:0];
        motor_type_q <= reg_wdata[PWC_MOTOR_TYPE_LSB +: 8];
      end
      if (wr_hit(PWC_ADDR_EXT_ANGLE)) begin
        ext_angle_q <= reg_wdata[15:0];
      end
      if (wr_hit(PWC_ADDR_FA_DIR)) begin
        fa_dir_q <= reg_wdata[PWC_FA_DIR_BIT];
      end
      if (wr_hit(PWC_ADDR_FA_ACCEL)) begin
        fa_accel_q <= reg_wdata;
      end
      if (wr_hit(PWC_ADDR_FA_TARGET)) begin
        fa_target_q <= reg_wdata;
      end
      if (wr_hit(PWC_ADDR_VEL_LIMIT)) begin
        velocity_loop_limit_q <= {1'b0, reg_wdata[30:0]};
      end
    end
  end

  // Read data is registered and stands only in the cycle after the strobe.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        PWC_ADDR_ENC_WY_UX:  reg_rdata <= {encoder_sense_third, encoder_sense_first};
        PWC_ADDR_ENC_VN:     reg_rdata <= {16'h0000, encoder_sense_second};
        PWC_ADDR_POLARITY:   reg_rdata <= {30'h00000000, gate_polarity_bits_q};
        PWC_ADDR_PERIOD:     reg_rdata <= {20'h00000, period_count_field_q};
        PWC_ADDR_DEAD_TIME:  reg_rdata <= {16'h0000, high_side_dead_time_q, low_side_dead_time_q};
        PWC_ADDR_CHOP:       reg_rdata <= {23'h000000, space_vector_enable_q, chopper_mode_field_q};
        PWC_ADDR_MOTOR:      reg_rdata <= {8'h00, motor_type_q, pole_pairs_q};
        PWC_ADDR_EXT_ANGLE:  reg_rdata <= {16'h0000, ext_angle_q};
        PWC_ADDR_FA_DIR:     reg_rdata <= {19'h00000, fa_dir_q, 12'h000};
        PWC_ADDR_FA_ACCEL:   reg_rdata <= fa_accel_q;
        PWC_ADDR_FA_TARGET:  reg_rdata <= fa_target_q;
        PWC_ADDR_FA_VEL_ACT: reg_rdata <= fa_vel_q;
        PWC_ADDR_FA_PHI:     reg_rdata <= {16'h0000, fa_acc_q[31:16]};
        PWC_ADDR_VEL_LIMIT:  reg_rdata <= velocity_loop_limit_q;
        default:             reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Period counter runs 0 to the field value, so one period is field plus one clocks.
  assign period_start = (cnt_q == 12'h000);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 12'h000;
    end else if (cnt_q >= act_period_q) begin
      cnt_q <= 12'h000;
    end else begin
      cnt_q <= cnt_q + 12'h001;
    end
  end

  // New timing settings are adopted on the last count so they govern the next period whole.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      act_period_q    <= PWC_RST_PERIOD;
      act_dead_low_q  <= PWC_RST_DEAD_TIME;
      act_dead_high_q <= PWC_RST_DEAD_TIME;
      act_chop_q      <= PWC_RST_CHOP;
    end else if (cnt_q >= act_period_q) begin
      act_period_q    <= period_count_field_q;
      act_dead_low_q  <= low_side_dead_time_q;
      act_dead_high_q <= high_side_dead_time_q;
      act_chop_q      <= chopper_mode_field_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Space-vector offset: shifts all duties so the extremes centre in the period.
  logic [11:0] dmax;
  logic [11:0] dmin;
  logic [13:0] sv_off;
  logic [11:0] duty_eff [3];
  logic [2:0]  phase_used;

  assign sv_active = space_vector_enable_q && (motor_type_q == PWC_MOTOR_BLDC);

  // Returns a duty moved by the signed common offset and clamped between zero and the period.
  function automatic logic [11:0] sv_shift(input logic [11:0] d, input logic [13:0] off, input logic [11:0] top);
    logic signed [14:0] s;
    s = $signed({3'b000, d}) + $signed({off[13], off});
    if (s < 15'sd0) begin
      return 12'h000;
    end else if (s > $signed({3'b000, top})) begin
      return top;
    end else begin
      return s[11:0];
    end
  endfunction

  always_comb begin
    dmax = duty_u;
    dmin = duty_u;
    if (duty_v > dmax) dmax = duty_v;
    if (duty_w > dmax) dmax = duty_w;
    if (duty_v < dmin) dmin = duty_v;
    if (duty_w < dmin) dmin = duty_w;
  end

  // Offset is (top - max - min) / 2, kept signed in two spare bits.
  assign sv_off = 14'(($signed({2'b00, act_period_q}) - $signed({2'b00, dmax}) - $signed({2'b00, dmin})) >>> 1);

  assign duty_eff[0] = sv_active ? sv_shift(duty_u, sv_off, act_period_q) : duty_u;
  assign duty_eff[1] = sv_active ? sv_shift(duty_v, sv_off, act_period_q) : duty_v;
  assign duty_eff[2] = sv_active ? sv_shift(duty_w, sv_off, act_period_q) : duty_w;

  // Motor type picks which half bridges switch at all.
  always_comb begin
    unique case (motor_type_q)
      PWC_MOTOR_NONE:    phase_used = 3'b000;
      PWC_MOTOR_DC:      phase_used = 3'b011;
      PWC_MOTOR_STEPPER: phase_used = 3'b111;
      PWC_MOTOR_BLDC:    phase_used = 3'b111;
      default:           phase_used = 3'b000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per half bridge: chopper decode, dead-time insertion and output polarity.
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_phase
      logic        want_h;
      logic        want_l;
      logic        edge_on;
      logic        center_on;
      logic [12:0] twice_cnt;
      logic [7:0]  dt_h_q;
      logic [7:0]  dt_l_q;
      logic        on_h_q;
      logic        on_l_q;

      assign edge_on   = (cnt_q < duty_eff[gi]);
      assign twice_cnt = {cnt_q, 1'b0};
      // Centered pulse: on while twice the count is within the duty of the period middle.
      assign center_on = ({1'b0, twice_cnt} + {2'b00, duty_eff[gi]} >= {2'b00, act_period_q})
                      && (twice_cnt < {1'b0, act_period_q} + {1'b0, duty_eff[gi]});

      // Requested side states before dead time.
      always_comb begin
        want_h = 1'b0;
        want_l = 1'b0;
        if (phase_used[gi]) begin
          unique case (act_chop_q)
            PWC_CHOP_LOW_ON: begin
              want_l = 1'b1;
            end
            PWC_CHOP_HIGH_ON: begin
              want_h = 1'b1;
            end
            PWC_CHOP_LOW_PWM: begin
              want_l = edge_on;
            end
            PWC_CHOP_HI_PWM: begin
              want_h = edge_on;
            end
            PWC_CHOP_CENTER: begin
              want_h = center_on;
              want_l = !center_on;
            end
            default: begin
              want_h = 1'b0;
              want_l = 1'b0;
            end
          endcase
        end
      end

      // Gap counters reload while their side is idle or the other side conducts, from the new value at period end.
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          dt_h_q <= PWC_RST_DEAD_TIME;
          dt_l_q <= PWC_RST_DEAD_TIME;
        end else begin
          if (!want_h || on_l_q) begin
            dt_h_q <= (cnt_q >= act_period_q) ? high_side_dead_time_q : act_dead_high_q;
          end else if (dt_h_q != 8'h00) begin
            dt_h_q <= dt_h_q - 8'(PWC_DEAD_UNIT_CYC);
          end
          if (!want_l || on_h_q) begin
            dt_l_q <= (cnt_q >= act_period_q) ? low_side_dead_time_q : act_dead_low_q;
          end else if (dt_l_q != 8'h00) begin
            dt_l_q <= dt_l_q - 8'(PWC_DEAD_UNIT_CYC);
          end
        end
      end

      // A side turns on only after its gap has elapsed and never beside the other.
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          on_h_q <= 1'b0;
          on_l_q <= 1'b0;
        end else begin
          on_h_q <= want_h && !on_l_q && (dt_h_q == 8'h00);
          on_l_q <= want_l && !on_h_q && (dt_l_q == 8'h00);
        end
      end

      // Polarity bit set means the gate is active high.
      assign gate_high[gi] = on_h_q ~^ gate_polarity_bits_q[PWC_POL_HIGH_BIT];
      assign gate_low[gi]  = on_l_q ~^ gate_polarity_bits_q[PWC_POL_LOW_BIT];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Free angle generator: velocity ramps once per period, angle integrates it.
  logic signed [32:0] vel_up;
  logic signed [32:0] vel_dn;
  logic signed [31:0] vel_goal;
  logic signed [31:0] lim;

  assign lim = $signed(velocity_loop_limit_q);

  // Target clamped to the velocity limit.
  always_comb begin
    if ($signed(fa_target_q) > lim) begin
      vel_goal = lim;
    end else if ($signed(fa_target_q) < -lim) begin
      vel_goal = -lim;
    end else begin
      vel_goal = $signed(fa_target_q);
    end
  end

  assign vel_up = $signed({fa_vel_q[31], fa_vel_q}) + $signed({1'b0, fa_accel_q});
  assign vel_dn = $signed({fa_vel_q[31], fa_vel_q}) - $signed({1'b0, fa_accel_q});

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fa_vel_q <= 32'h00000000;
    end else if (period_start) begin
      if ($signed(fa_vel_q) < vel_goal) begin
        fa_vel_q <= (vel_up > $signed({vel_goal[31], vel_goal})) ? vel_goal : vel_up[31:0];
      end else if ($signed(fa_vel_q) > vel_goal) begin
        fa_vel_q <= (vel_dn < $signed({vel_goal[31], vel_goal})) ? vel_goal : vel_dn[31:0];
      end
    end
  end

  // Phase accumulator; its upper half is the generated angle.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fa_acc_q <= 32'h00000000;
    end else if (period_start) begin
      fa_acc_q <= fa_dir_q ? fa_acc_q - fa_vel_q : fa_acc_q + fa_vel_q;
    end
  end

  assign free_angle = fa_acc_q[31:16];

  ////////////////////////////////////////////////////////////////////////////
  // Electrical angle from mechanical angle, wrapping modulo one turn.
  logic [31:0] angle_prod;

  assign angle_prod   = mech_angle * pole_pairs_q;
  assign elec_angle_d = angle_prod[15:0];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      elec_angle <= 16'h0000;
    end else begin
      elec_angle <= elec_angle_d;
    end
  end

  assign ext_elec_angle = ext_angle_q;

endmodule // pwc_core

// *** test/pwc_core_sva.sv ***
module pwc_core_chk
  import pwc_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [15:0] encoder_sense_first,
  input wire logic [15:0] encoder_sense_second,
  input wire logic [15:0] encoder_sense_third,
  input wire logic [15:0] mech_angle,
  input wire logic [15:0] elec_angle,
  input wire logic [15:0] ext_elec_angle,
  input wire logic        sv_active,
  input wire logic        period_start,
  input wire logic [2:0]  gate_high,
  input wire logic [2:0]  gate_low
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0]  pol_q;
  logic        sv_q;
  logic [7:0]  mot_q;
  logic [15:0] pp_q;
  logic [2:0]  on_h;
  logic [2:0]  on_l;
  logic [15:0] prod;

  // Shadows of the settings that act at once, not at a period boundary.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pol_q <= PWC_RST_POLARITY;
      sv_q  <= 1'b0;
      mot_q <= PWC_RST_MOTOR_TYPE;
      pp_q  <= PWC_RST_POLE_PAIRS;
    end else if (reg_wr) begin
      if (reg_addr == PWC_ADDR_POLARITY) pol_q <= reg_wdata[1:0];
      if (reg_addr == PWC_ADDR_CHOP) sv_q <= reg_wdata[PWC_SV_EN_BIT];
      if (reg_addr == PWC_ADDR_MOTOR) mot_q <= reg_wdata[23:16];
      if (reg_addr == PWC_ADDR_MOTOR) pp_q <= reg_wdata[15:0];
    end
  end

  // Conducting state of each transistor, with the polarity undone.
  assign on_h = ~(gate_high ^ {3{pol_q[1]}});
  assign on_l = ~(gate_low ^ {3{pol_q[0]}});
  assign prod = 16'(mech_angle * pp_q);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside a read answer");
  a_no_shoot_through: assert property ((on_h & on_l) == 3'h0)
    else $error("both transistors of a half bridge on");
  a_sv_needs_bldc: assert property (sv_active == (sv_q && mot_q == PWC_MOTOR_BLDC))
    else $error("space vector active flag wrong");
  a_elec_angle_mul: assert property (elec_angle == $past(prod))
    else $error("electrical angle is not angle times pole pairs");
  a_ext_angle_wr: assert property (reg_wr && reg_addr == PWC_ADDR_EXT_ANGLE |=>
    ext_elec_angle == $past(reg_wdata[15:0])) else $error("external angle not taken");
  a_enc_second_rd: assert property (reg_rd && reg_addr == PWC_ADDR_ENC_VN |=>
    reg_rdata == {16'h0, $past(encoder_sense_second)}) else $error("second encoder view wrong");
  a_enc_packed_rd: assert property (reg_rd && reg_addr == PWC_ADDR_ENC_WY_UX |=>
    reg_rdata == {$past(encoder_sense_third), $past(encoder_sense_first)}) else $error("packed encoder view wrong");
  a_motor_none_off: assert property ($past(mot_q) == PWC_MOTOR_NONE |-> (on_h | on_l) == 3'h0)
    else $error("gate on with no motor");
  a_dc_third_off: assert property ($past(mot_q) == PWC_MOTOR_DC |-> !on_h[2] && !on_l[2])
    else $error("third phase on for a single phase motor");

  c_period: cover property (period_start ##1 !period_start);
  c_low_on: cover property (on_l[0] && !on_h[0]);
  c_high_on: cover property (on_h[0] && !on_l[0]);
  c_sv: cover property (sv_active);
endmodule // pwc_core_chk

bind pwc_core pwc_core_chk pwc_core_chk_i (
  .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .encoder_sense_first(encoder_sense_first),
  .encoder_sense_second(encoder_sense_second), .encoder_sense_third(encoder_sense_third),
  .mech_angle(mech_angle), .elec_angle(elec_angle), .ext_elec_angle(ext_elec_angle),
  .sv_active(sv_active), .period_start(period_start), .gate_high(gate_high), .gate_low(gate_low)
);

// *** test/pwc_gate_drv.sv ***
module pwc_gate_drv (
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic [1:0] pol,
  input wire logic [2:0] gate_high,
  input wire logic [2:0] gate_low,
  output logic     [2:0] phase_node,
  output int             shoot_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] hs_on;
  logic [2:0] ls_on;

  // The driver is strapped for the same gate polarity as the controller.
  assign hs_on = ~(gate_high ^ {3{pol[1]}});
  assign ls_on = ~(gate_low ^ {3{pol[0]}});

  // A floating switch node shows the inverse of its last level; cross conduction is counted.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_node <= 3'h0;
      shoot_cnt  <= 0;
    end else begin
      phase_node <= (hs_on & ~ls_on) | (~hs_on & ~ls_on & ~phase_node);
      if ((hs_on & ls_on) != 3'h0) shoot_cnt <= shoot_cnt + 1;
    end
  end
endmodule // pwc_gate_drv

// *** test/test_pwm_and_free_angle_config.sv ***
module test_pwm_and_free_angle_config
  import pwc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [31:0] FA_ACC = 32'h00008000;
  localparam logic [31:0] FA_TGT = 32'h00040000;
  localparam logic [7:0]  RA [9] = '{PWC_ADDR_POLARITY, PWC_ADDR_PERIOD, PWC_ADDR_DEAD_TIME, PWC_ADDR_CHOP,
    PWC_ADDR_MOTOR, PWC_ADDR_EXT_ANGLE, PWC_ADDR_FA_DIR, PWC_ADDR_FA_ACCEL, PWC_ADDR_FA_TARGET};
  localparam logic [31:0] RM [9] = '{32'h3, 32'hFFF, 32'hFFFF, 32'h1FF, 32'hFFFFFF, 32'hFFFF, 32'h1000,
    32'hFFFFFFFF, 32'hFFFFFFFF};
  localparam logic [31:0] RV [6] = '{{30'h0, PWC_RST_POLARITY}, {20'h0, PWC_RST_PERIOD},
    {16'h0, PWC_RST_DEAD_TIME, PWC_RST_DEAD_TIME}, {24'h0, PWC_RST_CHOP},
    {8'h0, PWC_RST_MOTOR_TYPE, PWC_RST_POLE_PAIRS}, 32'h0};

  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [11:0] duty_u = 12'h0;
  logic [11:0] duty_v = 12'h0;
  logic [11:0] duty_w = 12'h0;
  logic [15:0] encoder_sense_first = 16'h0;
  logic [15:0] encoder_sense_second = 16'h0;
  logic [15:0] encoder_sense_third = 16'h0;
  logic [15:0] mech_angle = 16'h0;
  logic [15:0] elec_angle;
  logic [15:0] ext_elec_angle;
  logic [15:0] free_angle;
  logic        sv_active;
  logic        period_start;
  logic [2:0]  gate_high;
  logic [2:0]  gate_low;
  logic [1:0]  pol_cfg = 2'h3;
  logic [2:0]  on_h;
  logic [2:0]  on_l;
  int          shoot_cnt;
  int          miscompares = 0;
  int          total_checks = 0;

  pwc_core pwc_core_i (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .duty_u(duty_u), .duty_v(duty_v), .duty_w(duty_w),
    .encoder_sense_first(encoder_sense_first), .encoder_sense_second(encoder_sense_second),
    .encoder_sense_third(encoder_sense_third), .mech_angle(mech_angle), .elec_angle(elec_angle),
    .ext_elec_angle(ext_elec_angle), .free_angle(free_angle), .sv_active(sv_active),
    .period_start(period_start), .gate_high(gate_high), .gate_low(gate_low));
  pwc_gate_drv pwc_gate_drv_i (.clk(clk), .rst_b(rst_b), .pol(pol_cfg), .gate_high(gate_high),
    .gate_low(gate_low), .phase_node(), .shoot_cnt(shoot_cnt));

  // Clock and the conducting state of each phase.
  always #5 clk = ~clk;
  assign on_h = ~(gate_high ^ {3{pol_cfg[1]}});
  assign on_l = ~(gate_low ^ {3{pol_cfg[0]}});

  // Expected on-cycles per period of one side (1 low, 2 high) for a chopper mode.
  function automatic logic [31:0] exp_on(int m, int side, logic [11:0] d);
    if (m == side) return 32'h10;
    if (m == side + 4) return 32'(d);
    return 32'h0;
  endfunction

  // Phases that motor types 0, 1 and 3 drive; type 2 (stepper) gives none here, though the core drives all three.
  function automatic logic [2:0] exp_ph(int t);
    return (t == 3) ? 3'h7 : (t == 1) ? 3'h3 : 3'h0;
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask

  task automatic wait_ps();
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (period_start !== 1'b1 && n < 5000);
    if (n >= 5000) chk("period start", 32'h1, 32'h0);
  endtask

  task automatic finish_test();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Watchdog sized well beyond the longest expected run.
  initial begin
    #400000;
    miscompares++;
    finish_test();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    logic [31:0] v;
    logic [31:0] w;
    logic [15:0] pp;
    logic [15:0] a0;
    int          lo;
    int          hi;
    int          d;
    int          n;
    logic        early;
    void'($urandom(32'h1349));
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(RA[i], v);
      chk("reset value", RV[i], v);
    end
    for (int i = 0; i < 9; i++) begin
      w = $urandom & RM[i];
      wr(RA[i], w);
      if (i == 0) pol_cfg <= w[1:0];
      rd(RA[i], v);
      chk("readback", w, v);
    end
    @(posedge clk);
    encoder_sense_first <= 16'($urandom);
    encoder_sense_second <= 16'($urandom);
    encoder_sense_third <= 16'($urandom);
    wr(PWC_ADDR_ENC_VN, 32'hFFFFFFFF);
    rd(PWC_ADDR_ENC_WY_UX, v);
    chk("packed encoder view", {encoder_sense_third, encoder_sense_first}, v);
    rd(PWC_ADDR_ENC_VN, v);
    chk("second encoder view", {16'h0, encoder_sense_second}, v);
    rd(8'h40, v);
    chk("unmapped read", 32'h0, v);
    wr(PWC_ADDR_PERIOD, 32'h0000000F);
    wr(PWC_ADDR_DEAD_TIME, 32'h0);
    wr(PWC_ADDR_MOTOR, 32'h00030001);
    wr(PWC_ADDR_POLARITY, 32'h3);
    pol_cfg <= 2'h3;
    for (int m = 0; m < 9; m++) begin
      @(posedge clk);
      duty_u <= 12'($urandom_range(2, 14)); // A one-count centred pulse is lost in the interlock gap.
      duty_v <= 12'($urandom_range(1, 14));
      duty_w <= 12'($urandom_range(1, 14));
      wr(PWC_ADDR_CHOP, 32'(m));
      repeat (3) wait_ps();
      lo = 0;
      hi = 0;
      repeat (16) begin
        @(negedge clk);
        lo += int'(on_l[0]);
        hi += int'(on_h[0]);
      end
      chk("period length", 32'h1, 32'(period_start));
      if (m == 7) chk("centered", 32'h1, 32'(hi > 0 && lo > 0 && hi + lo <= 16));
      else begin
        chk("low count", exp_on(m, 1, duty_u), 32'(lo));
        chk("high count", exp_on(m, 2, duty_u), 32'(hi));
      end
    end
    for (int s = 0; s < 2; s++) begin
      d = $urandom_range(2, 9);
      wr(PWC_ADDR_CHOP, 32'h0);
      repeat (2) wait_ps();
      wr(PWC_ADDR_DEAD_TIME, {16'h0, 8'(d), 8'(d)});
      wr(PWC_ADDR_CHOP, 32'(s + 1));
      n = 0;
      early = 1'b0;
      do begin
        @(negedge clk);
        early = early | on_l[0] | on_h[0];
        n++;
      end while (period_start !== 1'b1 && n < 40);
      chk("early switch", 32'h0, 32'(early));
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (((s == 0) ? on_l[0] : on_h[0]) !== 1'b1 && n < 20);
      chk("turn on delay", 32'(d + 1), 32'(n));
    end
    wr(PWC_ADDR_DEAD_TIME, 32'h0);
    wr(PWC_ADDR_CHOP, 32'h00000101);
    for (int t = 0; t < 4; t++) begin
      if (t == 2) continue;
      pp = 16'($urandom_range(1, 9));
      wr(PWC_ADDR_MOTOR, {8'h00, 8'(t), pp});
      wr(PWC_ADDR_POLARITY, 32'(t));
      pol_cfg <= 2'(t);
      mech_angle <= 16'($urandom);
      repeat (3) wait_ps();
      chk("low gates", {29'h0, ~(exp_ph(t) ^ {3{pol_cfg[0]}})}, {29'h0, gate_low});
      chk("high gates", {29'h0, {3{~pol_cfg[1]}}}, {29'h0, gate_high});
      chk("space vector", 32'(t == 3), 32'(sv_active));
      chk("electrical angle", {16'h0, 16'(mech_angle * pp)}, {16'h0, elec_angle});
    end
    wr(PWC_ADDR_CHOP, 32'h0);
    wr(PWC_ADDR_FA_ACCEL, 32'h10000000);
    wr(PWC_ADDR_FA_TARGET, 32'h0);
    repeat (12) wait_ps();
    wr(PWC_ADDR_FA_DIR, 32'h0);
    wr(PWC_ADDR_FA_ACCEL, FA_ACC);
    wr(PWC_ADDR_FA_TARGET, FA_TGT);
    for (int k = 0; k < 12; k++) begin
      wait_ps();
      rd(PWC_ADDR_FA_VEL_ACT, v);
      chk("velocity ramp", 32'h1, 32'(v[14:0] == 15'h0 && v <= FA_TGT));
    end
    chk("velocity settled", FA_TGT, v);
    for (int dr = 0; dr < 2; dr++) begin
      wr(PWC_ADDR_FA_DIR, 32'(dr) << PWC_FA_DIR_BIT);
      repeat (2) wait_ps();
      a0 = free_angle;
      wait_ps();
      chk("angle step", (dr == 1) ? 32'h0000FFFC : 32'h4, {16'h0, 16'(free_angle - a0)});
    end
    chk("cross conduction", 32'h0, 32'(shoot_cnt));
    finish_test();
  end
endmodule // test_pwm_and_free_angle_config
